// [nbc_pkg.sv]
/*
 nbc_pkg: register map, field positions, sizes and command kinds of the
 nand block select and byte count block.
 assumes: shared by the register front end and the block sequencer.
*/
package nbc_pkg;
   // widths
   localparam int CNT_W = 11;
   localparam int MASK_W = 19;
   localparam int LEN_W = 12;
   localparam int IDX_W = 5;
   localparam int OFS_W = 16;
   localparam int ADDR_W = 12;
   // register byte addresses
   localparam logic [11:0] ADDR_BLOCK_SELECT = 12'h01c;
   localparam logic [11:0] ADDR_BYTE_COUNTER = 12'h020;
   localparam logic [11:0] ADDR_CONTROL = 12'h040;
   localparam logic [11:0] ADDR_STATUS = 12'h044;
   // reset values
   localparam logic [18:0] BLOCK_SELECT_RESET = 19'h00000;
   localparam logic [10:0] BYTE_COUNT_RESET = 11'h000;
   // control register fields
   localparam int CTRL_KIND_LSB = 0;
   localparam int CTRL_LDPC_BIT = 2;
   localparam int CTRL_DIR_BIT = 3;
   localparam int CTRL_START_BIT = 8;
   // status register fields
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_IDX_LSB = 8;
   // sizes
   localparam logic [11:0] ZERO_COUNT_LEN = 12'h400;
   localparam logic [15:0] BCH_BLOCK_BYTES = 16'h0400;
   localparam logic [15:0] LDPC_BLOCK_BYTES = 16'h0800;
   localparam logic [4:0] BCH_LAST_BLOCK = 5'h12;
   localparam logic [4:0] LDPC_LAST_BLOCK = 5'h0f;
   // command kinds
   typedef enum logic [1:0]
   {
      KIND_NORMAL = 2'h0,
      KIND_SPARE = 2'h1,
      KIND_BATCH = 2'h2,
      KIND_RESERVED = 2'h3
   } nbc_kind_type;
endpackage

// [nbc_ctl_if.sv]
/*
 nbc_ctl_if: control and transfer signals between the register front end
 and the block sequencer.
 assumes: both ends on pclk.
*/
`timescale 1ns/1ps
`default_nettype none
interface nbc_ctl_if;
   logic start;
   nbc_pkg::nbc_kind_type command_kind;
   logic ldpc;
   logic dir;
   logic [nbc_pkg::MASK_W-1:0] block_select_bits;
   logic [nbc_pkg::CNT_W-1:0] transfer_byte_count;
   logic busy;
   logic [nbc_pkg::IDX_W-1:0] block;
   logic xfer_req;
   logic xfer_done;
   logic [nbc_pkg::LEN_W-1:0] xfer_len;
   logic [nbc_pkg::OFS_W-1:0] xfer_offset;
   logic cmd_done;
   modport regs (output start, command_kind, ldpc, dir, block_select_bits,
      transfer_byte_count, xfer_done, input busy, block, xfer_req, xfer_len,
      xfer_offset, cmd_done);
   modport seq (input start, command_kind, ldpc, dir, block_select_bits,
      transfer_byte_count, xfer_done, output busy, block, xfer_req, xfer_len,
      xfer_offset, cmd_done);
endinterface
`default_nettype wire

// [nbc_seq.sv]
/*
 nbc_seq: walks the selected data blocks of a command and raises one
 transfer request per block.
 assumes: xfer_done is a one-cycle pulse from the data path while requested.
*/
`timescale 1ns/1ps
`default_nettype none
module nbc_seq
(
   input wire logic pclk,
   input wire logic presetn,
   nbc_ctl_if.seq ctl
);
   typedef enum logic [2:0]
   {
      S_IDLE = 3'b001,
      S_SCAN = 3'b010,
      S_XFER = 3'b100
   } nbc_seq_state_type;

   typedef struct packed
   {
      nbc_seq_state_type state;
      logic batch;
      logic ldpc;
      logic [nbc_pkg::MASK_W-1:0] mask;
      logic [nbc_pkg::IDX_W-1:0] idx;
      logic [nbc_pkg::LEN_W-1:0] len;
      logic [nbc_pkg::OFS_W-1:0] offset;
      logic done;
   } nbc_seq_reg_type;

   nbc_seq_reg_type r;
   nbc_seq_reg_type next_r;
   logic [nbc_pkg::IDX_W-1:0] last_block;
   logic [nbc_pkg::OFS_W-1:0] block_bytes;

   // ldpc pages hold fewer, larger blocks
   assign last_block = r.ldpc ? nbc_pkg::LDPC_LAST_BLOCK
      : nbc_pkg::BCH_LAST_BLOCK; // RULE4
   assign block_bytes = r.ldpc ? nbc_pkg::LDPC_BLOCK_BYTES
      : nbc_pkg::BCH_BLOCK_BYTES; // RULE2 RULE3

   // next state of the block walk
   always_comb
   begin
      next_r = r;
      next_r.done = 1'b0;
      case (r.state)
         S_IDLE:
         begin
            if (ctl.start && ctl.command_kind != nbc_pkg::KIND_RESERVED)
            begin
               next_r.batch = (ctl.command_kind == nbc_pkg::KIND_BATCH);
               next_r.ldpc = ctl.ldpc;
               // upper select bits mean nothing under ldpc
               next_r.mask = ctl.block_select_bits;
               if (ctl.ldpc)
               begin
                  next_r.mask[nbc_pkg::MASK_W-1:16] = 3'h0; // RULE4
               end
               // zero means 1024 bytes, a full block only under bch (an ldpc block is 2048)
               next_r.len = (ctl.transfer_byte_count == '0)
                  ? nbc_pkg::ZERO_COUNT_LEN
                  : {1'b0, ctl.transfer_byte_count}; // RULE5 RULE6 RULE7
               next_r.idx = '0;
               next_r.offset = '0;
               // normal and spare commands ignore the mask
               next_r.state = (ctl.command_kind == nbc_pkg::KIND_BATCH)
                  ? S_SCAN : S_XFER; // RULE10 RULE11
            end
         end
         S_SCAN:
         begin
            if (r.idx > last_block)
            begin
               next_r.state = S_IDLE;
               next_r.done = 1'b1;
            end
            else if (r.mask[r.idx])
            begin
               next_r.offset = nbc_pkg::OFS_W'(r.idx * block_bytes);
               next_r.state = S_XFER; // RULE1
            end
            else
            begin
               next_r.idx = r.idx + 5'h01; // RULE1
            end
         end
         S_XFER:
         begin
            if (ctl.xfer_done)
            begin
               if (r.batch)
               begin
                  next_r.idx = r.idx + 5'h01;
                  next_r.state = S_SCAN;
               end
               else
               begin
                  next_r.state = S_IDLE;
                  next_r.done = 1'b1;
               end
            end
         end
         default:
         begin
            next_r.state = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         r <= '{state: S_IDLE, default: '0};
      end
      else
      begin
         r <= next_r;
      end
   end

   assign ctl.busy = (r.state != S_IDLE);
   assign ctl.block = r.idx;
   assign ctl.xfer_req = (r.state == S_XFER);
   assign ctl.xfer_len = r.len;
   assign ctl.xfer_offset = r.offset;
   assign ctl.cmd_done = r.done;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   skip_unselected_a: assert property (r.state == S_SCAN && r.idx <= last_block
      && !r.mask[r.idx] |=> r.state == S_SCAN) // RULE1
      else $error("unselected block was not skipped");
   ldpc_upper_a: assert property (r.ldpc && r.state != S_IDLE
      |-> r.mask[18:16] == 3'h0) // RULE4
      else $error("upper select bits live under ldpc");
   bch_offset_a: assert property (ctl.xfer_req && r.batch && !r.ldpc
      |-> r.offset == nbc_pkg::OFS_W'(r.idx * nbc_pkg::BCH_BLOCK_BYTES)) // RULE2
      else $error("bch block offset wrong");
   ldpc_offset_a: assert property (ctl.xfer_req && r.batch && r.ldpc
      |-> r.offset == nbc_pkg::OFS_W'(r.idx * nbc_pkg::LDPC_BLOCK_BYTES)
      && r.idx <= nbc_pkg::LDPC_LAST_BLOCK) // RULE3
      else $error("ldpc block offset wrong");
   single_xfer_a: assert property (r.state == S_IDLE && ctl.start
      && (ctl.command_kind == nbc_pkg::KIND_NORMAL
      || ctl.command_kind == nbc_pkg::KIND_SPARE) |=> ctl.xfer_req) // RULE11
      else $error("single command did not request at once");
   zero_len_a: assert property (r.state == S_IDLE && ctl.start
      && ctl.transfer_byte_count == '0
      && ctl.command_kind != nbc_pkg::KIND_RESERVED
      |=> ctl.xfer_len == nbc_pkg::ZERO_COUNT_LEN) // RULE6
      else $error("zero count not taken as 1024");
   reserved_kind_a: assert property (r.state == S_IDLE && ctl.start
      && ctl.command_kind == nbc_pkg::KIND_RESERVED |=> !ctl.busy) // RULE10
      else $error("reserved kind started");
   len_hold_a: assert property (ctl.busy && $past(ctl.busy)
      |-> $stable(ctl.xfer_len)) // RULE7
      else $error("length changed mid command");

   batch_cover: cover property (r.batch && ctl.cmd_done);
   ldpc_cover: cover property (r.ldpc && r.batch && ctl.xfer_done);
   single_cover: cover property (!r.batch && ctl.cmd_done);
endmodule
`default_nettype wire

// [nbc_top.sv]
/*
 nbc_top: apb register front end for block selection and the transfer
 byte counter, driving the block sequencer.
 assumes: apb master per protocol, data path acknowledges each requested
 block with a one-cycle xfer_done.
*/
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RULE1 - batch: handle block only if its bit set
// RULE2 - bch: each block is 1024 bytes
// RULE3 - ldpc: blocks 0..15 are 2048 bytes
// RULE4 - ldpc: select bits 18..16 ignored
// RULE5 - eleven bit count sets block length
// RULE6 - count zero means 1024 bytes
// RULE7 - count applies to reads and writes
// RULE8 - channel 0: count at most/exactly 1024; no channel or limit here, any count up to 2047 is used
// RULE9 - channel 1: count at most/exactly 2048; no channel or limit here, 2048 cannot be set (zero gives 1024)
// RULE10 - kind: 00 normal, 01 spare, 10 batch
// RULE11 - mask used only for batch commands
module nbc_top
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [nbc_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic xfer_req,
   output logic xfer_write,
   output logic [nbc_pkg::IDX_W-1:0] xfer_block,
   output logic [nbc_pkg::LEN_W-1:0] xfer_len,
   output logic [nbc_pkg::OFS_W-1:0] xfer_offset,
   input wire logic xfer_done,
   output logic cmd_done
);
   typedef struct packed
   {
      logic [nbc_pkg::MASK_W-1:0] select;
      logic [nbc_pkg::CNT_W-1:0] count;
      nbc_pkg::nbc_kind_type kind;
      logic ldpc;
      logic dir;
      logic start;
      logic [31:0] rdata;
      logic err;
   } nbc_top_reg_type;

   nbc_top_reg_type r;
   nbc_top_reg_type next_r;
   nbc_ctl_if ctl ();
   logic access;
   logic wr;
   logic rd;
   logic hit;

   // every access completes in its first access cycle
   assign access = psel && penable;
   assign wr = access && pwrite;
   assign rd = access && !pwrite;
   assign hit = (paddr == nbc_pkg::ADDR_BLOCK_SELECT)
      || (paddr == nbc_pkg::ADDR_BYTE_COUNTER)
      || (paddr == nbc_pkg::ADDR_CONTROL)
      || (paddr == nbc_pkg::ADDR_STATUS);

   // register writes and read data capture
   always_comb
   begin
      next_r = r;
      next_r.start = 1'b0;
      next_r.err = 1'b0;
      // read data shows only in a read access, never a stale word
      next_r.rdata = '0;
      if (wr)
      begin
         case (paddr)
            nbc_pkg::ADDR_BLOCK_SELECT:
            begin
               next_r.select = pwdata[nbc_pkg::MASK_W-1:0]; // RULE1
            end
            nbc_pkg::ADDR_BYTE_COUNTER:
            begin
               next_r.count = pwdata[nbc_pkg::CNT_W-1:0]; // RULE5
            end
            nbc_pkg::ADDR_CONTROL:
            begin
               // settings are frozen while a command runs
               if (!ctl.busy)
               begin
                  next_r.kind = nbc_pkg::nbc_kind_type'(
                     pwdata[nbc_pkg::CTRL_KIND_LSB+:2]); // RULE10
                  next_r.ldpc = pwdata[nbc_pkg::CTRL_LDPC_BIT];
                  next_r.dir = pwdata[nbc_pkg::CTRL_DIR_BIT]; // RULE7
                  next_r.start = pwdata[nbc_pkg::CTRL_START_BIT];
               end
            end
            default:
            begin
               next_r.err = !hit;
            end
         endcase
      end
      if (rd)
      begin
         next_r.rdata = '0;
         next_r.err = !hit;
         case (paddr)
            nbc_pkg::ADDR_BLOCK_SELECT:
            begin
               next_r.rdata[nbc_pkg::MASK_W-1:0] = r.select;
            end
            nbc_pkg::ADDR_BYTE_COUNTER:
            begin
               next_r.rdata[nbc_pkg::CNT_W-1:0] = r.count;
            end
            nbc_pkg::ADDR_CONTROL:
            begin
               next_r.rdata[nbc_pkg::CTRL_KIND_LSB+:2] = r.kind;
               next_r.rdata[nbc_pkg::CTRL_LDPC_BIT] = r.ldpc;
               next_r.rdata[nbc_pkg::CTRL_DIR_BIT] = r.dir;
            end
            nbc_pkg::ADDR_STATUS:
            begin
               next_r.rdata[nbc_pkg::STAT_BUSY_BIT] = ctl.busy;
               next_r.rdata[nbc_pkg::STAT_IDX_LSB+:nbc_pkg::IDX_W] = ctl.block;
            end
            default:
            begin
               next_r.rdata = '0;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         r <= '{select: nbc_pkg::BLOCK_SELECT_RESET,
            count: nbc_pkg::BYTE_COUNT_RESET, kind: nbc_pkg::KIND_NORMAL,
            default: '0};
      end
      else
      begin
         r <= next_r;
      end
   end

   // zero wait states: prdata is the decode of this very access, so it is
   // valid only while the access phase stands
   assign pready = 1'b1;
   assign prdata = next_r.rdata;
   assign pslverr = access && !hit;

   // settings toward the sequencer
   assign ctl.start = r.start;
   assign ctl.command_kind = r.kind;
   assign ctl.ldpc = r.ldpc;
   assign ctl.dir = r.dir;
   assign ctl.block_select_bits = r.select;
   assign ctl.transfer_byte_count = r.count;
   assign ctl.xfer_done = xfer_done;

   nbc_seq u_seq
   (
      .pclk(pclk),
      .presetn(presetn),
      .ctl(ctl)
   );

   // data path side
   assign xfer_req = ctl.xfer_req;
   assign xfer_write = r.dir;
   assign xfer_block = ctl.block;
   assign xfer_len = ctl.xfer_len;
   assign xfer_offset = ctl.xfer_offset;
   assign cmd_done = ctl.cmd_done;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   count_store_a: assert property (wr && paddr == nbc_pkg::ADDR_BYTE_COUNTER
      |=> r.count == $past(pwdata[nbc_pkg::CNT_W-1:0])) // RULE5
      else $error("byte count not stored");
   select_store_a: assert property (wr && paddr == nbc_pkg::ADDR_BLOCK_SELECT
      |=> r.select == $past(pwdata[nbc_pkg::MASK_W-1:0])) // RULE1
      else $error("select bits not stored");
   unmapped_err_a: assert property (access && !hit |-> pslverr
      && prdata == 32'h0)
      else $error("unmapped access not refused");
   dir_out_a: assert property (xfer_req |-> xfer_write == r.dir) // RULE7
      else $error("direction not passed out");

   write_cover: cover property (xfer_req && xfer_write && xfer_done);
   read_cover: cover property (xfer_req && !xfer_write && xfer_done);
endmodule
`default_nettype wire

// [nbc_flash_model.sv]
/*
 nbc_flash_model: behavioural stand-in for the flash data path that serves
 one block transfer per request of the block sequencer.
 assumes: xfer_req stands until a done pulse is seen, lat is set by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module nbc_flash_model
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic xfer_req,
   input wire logic [3:0] lat,
   output logic xfer_done
);
   logic [3:0] cnt;

   // ack each block lat+1 cycles after its request; done drops at once so one request
   // is never acknowledged twice
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt <= 4'h0;
         xfer_done <= 1'b0;
      end
      else if (xfer_req && !xfer_done)
      begin
         xfer_done <= (cnt >= lat);
         cnt <= (cnt >= lat) ? 4'h0 : cnt + 4'h1;
      end
      else
      begin
         cnt <= 4'h0;
         xfer_done <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// [nbc_tb.sv]
/*
 tb: self-checking bench for nbc_top; apb driver notes expected reads and
 transfers in queues, a monitor compares them as they appear.
 assumes: zero-wait apb slave, flash model answering each block request.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic xfer_req, xfer_write, xfer_done, cmd_done;
   logic [4:0] xfer_block;
   logic [11:0] xfer_len;
   logic [15:0] xfer_offset;
   logic [3:0] lat;
   logic [33:0] xq[$];
   logic [32:0] rq[$];
   logic [33:0] e;
   int num_errors, n_compared, n_cmd, cycles;

   nbc_top nbc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .xfer_req(xfer_req), .xfer_write(xfer_write), .xfer_block(xfer_block),
      .xfer_len(xfer_len), .xfer_offset(xfer_offset),
      .xfer_done(xfer_done), .cmd_done(cmd_done));
   nbc_flash_model nbc_flash_model_i (.pclk(pclk), .presetn(presetn),
      .xfer_req(xfer_req), .lat(lat), .xfer_done(xfer_done));

   always #5 pclk = ~pclk;

   task automatic chk(input string nm, input logic [63:0] x,
      input logic [63:0] g);
      n_compared++;
      if (x !== g)
      begin
         num_errors++;
         $display("[FAIL] %s expected %0h seen %0h", nm, x, g);
      end
   endtask

   task automatic finish_test();
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // apb transfer: request held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [32:0] x);
      rq.push_back(x);
      apb(1'b0, a, 32'h0);
   endtask

   // one command: expected blocks noted first, then registers and start
   task automatic run(input logic [1:0] k, input logic ld, input logic dr,
      input logic [18:0] m, input logic [10:0] c);
      int n;
      logic [11:0] len;
      len = (c == 11'h0) ? nbc_pkg::ZERO_COUNT_LEN : {1'b0, c};
      if (k == 2'h2)
         for (int i = 0; i < 19; i++)
         begin
            if (m[i] && !(ld && i > 15))
               xq.push_back({dr, len, 16'(i) * (ld ? nbc_pkg::LDPC_BLOCK_BYTES
                  : nbc_pkg::BCH_BLOCK_BYTES), 5'(i)});
         end
      else if (k != 2'h3)
         xq.push_back({dr, len, 16'h0, 5'h0});
      n = n_cmd;
      apb(1'b1, nbc_pkg::ADDR_BLOCK_SELECT, {13'($urandom), m});
      apb(1'b1, nbc_pkg::ADDR_BYTE_COUNTER, {21'($urandom), c});
      apb(1'b1, nbc_pkg::ADDR_CONTROL, {23'h0, 1'b1, 4'h0, dr, ld, k});
      for (int t = 0; t < 600 && n_cmd == n; t++)
         @(posedge pclk);
      chk("cmd_done", k != 2'h3, n_cmd - n);
      chk("blocks left", 0, xq.size());
      $display("test kind %0d ldpc %0d dir %0d done", k, ld, dr);
   endtask

   // monitor: reads and finished block transfers against the queues
   always @(posedge pclk)
   begin
      if (psel && penable && pready && !pwrite)
         chk("read", rq.pop_front(), {pslverr, prdata});
      // only the bench's one unmapped place may answer a write with error
      if (psel && penable && pready && pwrite)
         chk("write error", paddr == 12'h0f0, pslverr);
      if (xfer_req === 1'b1 && xfer_done === 1'b1)
      begin
         e = (xq.size() != 0) ? xq.pop_front() : '1;
         chk("transfer", e, {xfer_write, xfer_len, xfer_offset,
            xfer_block});
      end
      if (cmd_done === 1'b1)
         n_cmd++;
   end

   // hang guard, well above the run length
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         num_errors++;
         finish_test();
      end
   end

   initial
   begin
      {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      lat = 4'h0;
      void'($urandom(32'hde9d7d55));
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      // reset values, unmapped place and field widths
      rd(nbc_pkg::ADDR_BLOCK_SELECT, 33'h0);
      rd(nbc_pkg::ADDR_BYTE_COUNTER, 33'h0);
      rd(nbc_pkg::ADDR_STATUS, 33'h0);
      rd(12'h0f0, {1'b1, 32'h0});
      apb(1'b1, 12'h0f0, 32'hffffffff);
      apb(1'b1, nbc_pkg::ADDR_BLOCK_SELECT, 32'hffffffff);
      rd(nbc_pkg::ADDR_BLOCK_SELECT, 33'h7ffff);
      apb(1'b1, nbc_pkg::ADDR_BYTE_COUNTER, 32'hffffffff);
      rd(nbc_pkg::ADDR_BYTE_COUNTER, 33'h7ff);
      $display("test registers done");
      // normal and spare ignore the mask; count up to 1024 or zero
      for (int k = 0; k < 2; k++)
         for (int d = 0; d < 2; d++)
         begin
            lat <= 4'($urandom);
            run(2'(k), 1'b0, 1'(d), 19'($urandom),
               d ? 11'h0 : 11'($urandom % 1025));
         end
      // batch in both ecc modes, both directions, random flash latency per run
      for (int l = 0; l < 2; l++)
         for (int d = 0; d < 2; d++)
         begin
            lat <= 4'($urandom);
            run(2'h2, 1'(l), 1'(d), 19'($urandom) | 19'h70001,
               d ? 11'h0 : 11'h400);
         end
      run(2'h2, 1'b1, 1'b0, 19'h70000, 11'h400);
      run(2'h2, 1'b0, 1'b1, 19'h0, 11'h400);
      // status while a batch walks the empty mask: busy, scanning block 1
      apb(1'b1, nbc_pkg::ADDR_CONTROL, 32'h102);
      rd(nbc_pkg::ADDR_STATUS, 33'h101);
      repeat (30) @(posedge pclk);
      $display("test status done");
      run(2'h3, 1'b0, 1'b0, 19'h7ffff, 11'h400);
      // control reads back its kind, start always reads 0
      rd(nbc_pkg::ADDR_CONTROL, 33'h3);
      $display("test control readback done");
      finish_test();
   end
endmodule
`default_nettype wire
